// [design/erxcs_pkg.sv]
// package for the receive client status block
// ==========================================================================
// Summary of operation
// - fcs error with eop unless alignment off
// - runt frames always flag fcs error
// - packets of eight bytes or fewer: decode error
// - fcs valid exactly when fcs error meaningful
// - control type meaningful only in eop cycles
// - bit0 standard pause, zero when standard mode on and not forwarded
// - bit1 priority pause, zero when priority mode on and not forwarded
// - bit2 control frame not flow control
// - word valid whenever data valid
// - rx mac clock from recovered clock
// - payload bytes have control flag zero
// - preamble start flag one, rest zero
// - external tx pll option selects tx clock
// - crc error bit equals fcs error, a cycle ahead of it when alignment off
// ==========================================================================
package erxcs_pkg;
  // ========================================================================
  // register map (byte addresses)
  localparam logic [11:0] ERXCS_CTRL_OFS = 12'h000;
  localparam logic [11:0] ERXCS_STAT_OFS = 12'h004;
  localparam logic [11:0] ERXCS_IRQ_OFS = 12'h008;
  localparam logic [11:0] ERXCS_MASK_OFS = 12'h00C;
  localparam logic [11:0] ERXCS_CNT_OFS = 12'h010;
  // control fields
  localparam int ERXCS_CTRL_ALIGN = 0;
  localparam int ERXCS_CTRL_FWD = 1;
  localparam int ERXCS_CTRL_STD = 2;
  localparam int ERXCS_CTRL_PFC = 3;
  localparam int ERXCS_CTRL_PRE = 4;
  localparam int ERXCS_CTRL_EXTPLL = 5;
  localparam logic [5:0] ERXCS_CTRL_RST = 6'h01;
  // interrupt bits: fcs error, runt, decode error, control frame
  localparam int ERXCS_IRQ_W = 4;
  localparam int ERXCS_EV_FCS = 0;
  localparam int ERXCS_EV_RUNT = 1;
  localparam int ERXCS_EV_DEC = 2;
  localparam int ERXCS_EV_CTL = 3;
  // frame size limits
  localparam logic [15:0] ERXCS_DEC_MAX = 16'h0008;
  localparam logic [15:0] ERXCS_RUNT_MAX = 16'h003F;
  // control frame type encodings from the parser
  localparam logic [1:0] ERXCS_CT_NONE = 2'h0;
  localparam logic [1:0] ERXCS_CT_STD = 2'h1;
  localparam logic [1:0] ERXCS_CT_PFC = 2'h2;
  localparam logic [1:0] ERXCS_CT_OTHER = 2'h3;

  // per-frame summary from the upstream decoder
  typedef struct packed {
    logic eop;
    logic crc_bad;
    logic [15:0] len;
    logic [1:0] ctl;
  } erxcs_frame_t;

  // client-side status bundle
  typedef struct packed {
    logic fcs_error;
    logic fcs_valid;
    logic [2:0] status;
    logic [5:0] rx_error;
  } erxcs_stat_t;

  // byte lane: control flag plus data
  typedef struct packed {
    logic ctl;
    logic [7:0] data;
  } erxcs_byte_t;

  typedef enum logic [1:0] {
    ERXCS_ST_IDLE = 2'b00,
    ERXCS_ST_PRE = 2'b01,
    ERXCS_ST_DATA = 2'b11
  } erxcs_state_t;
endpackage

// [design/erxcs_top.sv]
// receive client status, byte encoding and clock selection
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
module erxcs_top #(
  parameter int DELAY_FCS = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire erxcs_pkg::erxcs_frame_t frame_in,
  input wire logic in_valid,
  input wire logic in_start,
  input wire logic in_sop,
  input wire logic [7:0] in_byte,
  input wire logic rx_cdr_clk,
  input wire logic tx_int_clk,
  input wire logic clk_txmac_in,
  output erxcs_pkg::erxcs_stat_t stat_out,
  output erxcs_pkg::erxcs_byte_t byte_out,
  output logic dout_valid,
  output logic clk_rxmac,
  output logic clk_txmac,
  output logic ext_tx_pll_option,
  output logic irq
);
  import erxcs_pkg::*;

  // ========================================================================
  // apb register state
  logic [5:0] ctrl_r, ctrl_nxt;
  logic [ERXCS_IRQ_W-1:0] irq_r, irq_nxt, mask_r, mask_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic irq_out_r, irq_out_nxt;

  // ========================================================================
  // status pipeline state
  erxcs_stat_t stat_r, stat_nxt;
  erxcs_byte_t byte_r, byte_nxt;
  erxcs_state_t st_r, st_nxt;
  logic valid_r, valid_nxt;
  logic late_r, late_nxt;
  logic late_err_r, late_err_nxt;
  logic [ERXCS_IRQ_W-1:0] ev;

  // upper address bits must be clear, so aliases are refused
  function automatic logic addr_hit(input logic [31:0] a,
                                    input logic [11:0] ofs);
    addr_hit = (a[11:2] == ofs[11:2]) && (a[31:12] == 20'h00000);
  endfunction

  wire fwd = ctrl_r[ERXCS_CTRL_FWD];
  wire align = ctrl_r[ERXCS_CTRL_ALIGN];
  // short frames are decode errors, never runts, never an fcs verdict
  wire runt = (frame_in.len > ERXCS_DEC_MAX)
              && (frame_in.len <= ERXCS_RUNT_MAX);
  wire decerr = frame_in.len <= ERXCS_DEC_MAX;
  wire eop = in_valid && frame_in.eop;
  wire fcs_bad = frame_in.crc_bad || runt;

  // ========================================================================
  // status computation
  always_comb begin
    stat_nxt = '0;
    late_nxt = 1'b0;
    late_err_nxt = 1'b0;
    ev = '0;
    if (eop && !decerr) begin
      if (align || DELAY_FCS == 0) begin
        stat_nxt.fcs_error = fcs_bad;
        stat_nxt.fcs_valid = 1'b1;
      end else begin
        // verdict held back one cycle; error and valid travel together
        late_nxt = 1'b1;
        late_err_nxt = fcs_bad;
      end
      stat_nxt.rx_error[1] = fcs_bad;
      stat_nxt.rx_error[2] = runt;
      // a suppressed pause frame shows no type bit at all
      case (frame_in.ctl)
        ERXCS_CT_STD: begin
          stat_nxt.status[0] = !(ctrl_r[ERXCS_CTRL_STD] && !fwd);
        end
        ERXCS_CT_PFC: begin
          stat_nxt.status[1] = !(ctrl_r[ERXCS_CTRL_PFC] && !fwd);
        end
        ERXCS_CT_OTHER: begin
          stat_nxt.status[2] = 1'b1;
        end
        default: begin
          stat_nxt.status = 3'h0;
        end
      endcase
    end
    // short frame: only the malformed bit, no fcs verdict
    if (eop && decerr) begin
      stat_nxt.rx_error[0] = 1'b1;
    end
    // unaligned mode: good and bad frames alike lag eop by one cycle
    if (late_r) begin
      stat_nxt.fcs_error = late_err_r;
      stat_nxt.fcs_valid = 1'b1;
    end
    // events last one cycle; the sticky bits hold them for software
    ev[ERXCS_EV_FCS] = eop && !decerr && fcs_bad;
    ev[ERXCS_EV_RUNT] = eop && runt;
    ev[ERXCS_EV_DEC] = eop && decerr;
    ev[ERXCS_EV_CTL] = eop && (frame_in.ctl != ERXCS_CT_NONE);
  end

  // ========================================================================
  // byte encoding
  always_comb begin
    st_nxt = st_r;
    byte_nxt.data = in_byte;
    byte_nxt.ctl = 1'b0;
    valid_nxt = in_valid;
    // idle cycles carry the control flag, as an idle character would
    case (st_r)
      ERXCS_ST_IDLE: begin
        if (in_valid && in_start) begin
          byte_nxt.ctl = ctrl_r[ERXCS_CTRL_PRE];
          st_nxt = ERXCS_ST_PRE;
        end else begin
          byte_nxt.ctl = !in_valid;
        end
      end
      ERXCS_ST_PRE: begin
        byte_nxt.ctl = 1'b0;
        if (in_valid && in_sop) begin
          st_nxt = ERXCS_ST_DATA;
        end
      end
      ERXCS_ST_DATA: begin
        byte_nxt.ctl = 1'b0;
        if (eop) begin
          st_nxt = ERXCS_ST_IDLE;
        end
      end
      default: begin
        st_nxt = ERXCS_ST_IDLE;
      end
    endcase
  end

  // ========================================================================
  // apb slave and interrupts
  always_comb begin
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    irq_nxt = irq_r | ev;
    // fcs error count wraps silently at its top
    cnt_nxt = cnt_r + {15'h0, ev[ERXCS_EV_FCS]};
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    // answer in the first access cycle: never a wait state
    if (psel && !penable) begin
      pready_nxt = 1'b1;
      prdata_nxt = 32'h00000000;
      if (addr_hit(paddr, ERXCS_CTRL_OFS)) begin
        prdata_nxt = {26'h0, ctrl_r};
      end else if (addr_hit(paddr, ERXCS_STAT_OFS)) begin
        prdata_nxt = {29'h0, stat_r.status};
      end else if (addr_hit(paddr, ERXCS_IRQ_OFS)) begin
        prdata_nxt = {28'h0000000, irq_r};
      end else if (addr_hit(paddr, ERXCS_MASK_OFS)) begin
        prdata_nxt = {28'h0000000, mask_r};
      end else if (addr_hit(paddr, ERXCS_CNT_OFS)) begin
        prdata_nxt = {16'h0000, cnt_r};
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
    if (psel && penable && pready_r && pwrite && !pslverr_r) begin
      if (addr_hit(paddr, ERXCS_CTRL_OFS)) begin
        ctrl_nxt = pwdata[5:0];
      end
      if (addr_hit(paddr, ERXCS_MASK_OFS)) begin
        mask_nxt = pwdata[ERXCS_IRQ_W-1:0];
      end
      if (addr_hit(paddr, ERXCS_IRQ_OFS)) begin
        // a new event in the clearing cycle survives
        irq_nxt = (irq_r & ~pwdata[ERXCS_IRQ_W-1:0]) | ev;
      end
      if (addr_hit(paddr, ERXCS_CNT_OFS)) begin
        cnt_nxt = 16'h0000;
      end
    end
    // taken from next state, so irq rises with its status bit
    irq_out_nxt = |(irq_nxt & mask_nxt);
  end

  // ========================================================================
  // register groups: apb and interrupts, status, byte lane
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= ERXCS_CTRL_RST;
      mask_r <= '0;
      irq_r <= '0;
      cnt_r <= 16'h0000;
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      irq_out_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
      cnt_r <= cnt_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_out_r <= irq_out_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= '0;
      late_r <= 1'b0;
      late_err_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      late_r <= late_nxt;
      late_err_r <= late_err_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_r <= '0;
      st_r <= ERXCS_ST_IDLE;
      valid_r <= 1'b0;
    end else begin
      byte_r <= byte_nxt;
      st_r <= st_nxt;
      valid_r <= valid_nxt;
    end
  end

  // ========================================================================
  // clocks: rx clock is the recovered one divided by two, tx clock selected by option
  logic rx_div_r, rx_div_nxt, tx_sel_r, tx_sel_nxt;
  logic [1:0] rx_rstn_r;

  // reset release retimed to the recovered clock, so the divider
  // never leaves reset on a clipped half period of that clock
  always_ff @(posedge rx_cdr_clk or negedge presetn) begin
    if (!presetn) begin
      rx_rstn_r <= 2'b00;
    end else begin
      rx_rstn_r <= {rx_rstn_r[0], 1'b1};
    end
  end

  always_comb begin
    rx_div_nxt = !rx_div_r;
  end

  always_ff @(posedge rx_cdr_clk or negedge rx_rstn_r[1]) begin
    if (!rx_rstn_r[1]) begin
      rx_div_r <= 1'b0;
    end else begin
      rx_div_r <= rx_div_nxt;
    end
  end

  // option bit follows the register one cycle later
  always_comb begin
    tx_sel_nxt = ctrl_r[ERXCS_CTRL_EXTPLL];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sel_r <= 1'b0;
    end else begin
      tx_sel_r <= tx_sel_nxt;
    end
  end
  // mux is not glitch free; change option only while tx path is idle
  always_comb begin
    clk_txmac = tx_sel_r ? clk_txmac_in : tx_int_clk;
  end

  assign clk_rxmac = rx_div_r;
  assign ext_tx_pll_option = tx_sel_r;
  assign stat_out = stat_r;
  assign byte_out = byte_r;
  assign dout_valid = valid_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_out_r;
endmodule

// [tb/erxcs_checker.sv]
// assertions on the receive client status ports
`timescale 1ns/1ps
module erxcs_checker
  import erxcs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire erxcs_pkg::erxcs_frame_t frame_in,
  input wire logic in_valid,
  input wire logic in_sop,
  input wire logic [7:0] in_byte,
  input wire erxcs_pkg::erxcs_stat_t stat_out,
  input wire erxcs_pkg::erxcs_byte_t byte_out,
  input wire logic dout_valid,
  input wire logic clk_txmac,
  input wire logic clk_txmac_in,
  input wire logic ext_tx_pll_option
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic eopi = in_valid && frame_in.eop;
  wire logic big = frame_in.len > ERXCS_DEC_MAX;
  // ==========================================================
  // status
  chk_fcs_qual: assert property (
    stat_out.fcs_error |-> stat_out.fcs_valid)
    else $error("fcs error without valid");
  chk_crc_mirror: assert property (
    stat_out.rx_error[1] |-> stat_out.fcs_error or ##1 stat_out.fcs_error)
    else $error("crc bit and fcs error differ");
  chk_runt_flag: assert property (
    eopi && big && frame_in.len <= ERXCS_RUNT_MAX
    |=> stat_out.rx_error[2] && stat_out.rx_error[1])
    else $error("runt without fcs error");
  chk_dec_norunt: assert property (
    eopi && !big |=> stat_out.rx_error[0] && !stat_out.rx_error[2])
    else $error("short packet flagged as runt");
  chk_status_eop: assert property (
    stat_out.status != 3'h0 |-> $past(eopi))
    else $error("control type outside eop cycle");
  chk_other_ctl: assert property (
    eopi && big && frame_in.ctl == ERXCS_CT_OTHER
    |=> stat_out.status == 3'h4)
    else $error("other control frame not flagged");
  // ==========================================================
  // data path and clocks
  chk_word_valid: assert property (
    1'b1 |=> dout_valid == $past(in_valid))
    else $error("word valid does not follow data");
  chk_sfd_ctl: assert property (
    in_valid && in_sop |=> !byte_out.ctl && byte_out.data == $past(in_byte))
    else $error("sfd byte encoding wrong");
  chk_txclk_sel: assert property (
    ext_tx_pll_option |-> clk_txmac == clk_txmac_in)
    else $error("tx clock not from external input");
endmodule
bind erxcs_top erxcs_checker erxcs_checker_inst (.pclk, .presetn,
  .frame_in, .in_valid, .in_sop, .in_byte, .stat_out, .byte_out,
  .dout_valid, .clk_txmac, .clk_txmac_in, .ext_tx_pll_option);

// [tb/erxcs_client.sv]
// client sink model that also sources the external tx clock
`timescale 1ns/1ps
module erxcs_client (
  input wire logic pclk,
  input wire erxcs_pkg::erxcs_stat_t stat_out,
  output logic clk_txmac_in,
  output int fcs_seen
);
  // pll fed by the reference clock, 312.5 MHz
  initial begin
    clk_txmac_in = 1'b0;
    forever #1.6 clk_txmac_in = ~clk_txmac_in;
  end
  initial fcs_seen = 0;
  always @(posedge pclk) begin
    if (stat_out.fcs_valid && stat_out.fcs_error) begin
      fcs_seen++;
    end
  end
endmodule

// [tb/erxcs_top_bench.sv]
// testbench for the receive client status block
`timescale 1ns/1ps
module erxcs_top_bench;
  import erxcs_pkg::*;
  typedef struct {logic [15:0] len; logic crc; logic [1:0] ctl;
    logic [4:0] ex;} erxcs_row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic in_valid = 0, in_start = 0, in_sop = 0, cdr = 0, txi = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic pready, pslverr, rerr, rxc, txc, txin, ext, irq, dv, rxv;
  logic [7:0] in_byte = '0;
  erxcs_frame_t frame_in = '0;
  erxcs_stat_t stat_out;
  erxcs_byte_t byte_out;
  int fail_count = 0, total_checks = 0, seen;
  // {fcs_valid, fcs_error, status}
  erxcs_row_t rows[7] = '{'{64, 0, ERXCS_CT_NONE, 5'h10},
    '{100, 1, ERXCS_CT_NONE, 5'h18}, '{20, 0, ERXCS_CT_NONE, 5'h18},
    '{8, 0, ERXCS_CT_NONE, 5'h00}, '{64, 0, ERXCS_CT_STD, 5'h11},
    '{64, 0, ERXCS_CT_PFC, 5'h12}, '{64, 0, ERXCS_CT_OTHER, 5'h14}};
  erxcs_top erxcs_top_inst (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .frame_in, .in_valid,
    .in_start, .in_sop, .in_byte, .rx_cdr_clk(cdr), .tx_int_clk(txi),
    .clk_txmac_in(txin), .stat_out, .byte_out, .dout_valid(dv),
    .clk_rxmac(rxc), .clk_txmac(txc), .ext_tx_pll_option(ext), .irq);
  erxcs_client erxcs_client_inst (.pclk, .stat_out, .clk_txmac_in(txin),
    .fcs_seen(seen));
  initial forever #4 pclk = ~pclk;
  initial forever #1.28 cdr = ~cdr;
  initial forever #1.6 txi = ~txi;
  task automatic chk(input logic [36:0] g, input logic [36:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic send(input logic [15:0] len, logic crc, logic [1:0] ct);
    @(posedge pclk);
    frame_in <= '{1'b1, crc, len, ct};
    in_valid <= 1'b1;
    @(posedge pclk);
    frame_in <= '0;
    in_valid <= 1'b0;
    #1;
  endtask
  task automatic put(input logic v, st, sop, input logic [7:0] b);
    @(posedge pclk);
    {in_valid, in_start, in_sop, in_byte} <= {v, st, sop, b};
    #1;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    finish_test;
  end
  initial begin
    repeat (16) @(posedge pclk);
    chk({stat_out, byte_out, rxc, dv, irq, ext}, '0);
    presetn <= 1'b1;
    apb(0, ERXCS_CTRL_OFS, 0);
    chk(rd, 32'h1);
    foreach (rows[i]) begin
      send(rows[i].len, rows[i].crc, rows[i].ctl);
      chk({stat_out.fcs_valid, stat_out.fcs_error, stat_out.status},
          rows[i].ex);
    end
    $display("table done");
    // standard and priority modes, forwarding off then on; then unaligned fcs timing
    apb(1, ERXCS_CTRL_OFS, 32'h0D);
    send(64, 0, ERXCS_CT_STD);
    chk(stat_out.status, 3'h0);
    send(64, 0, ERXCS_CT_PFC);
    chk(stat_out.status, 3'h0);
    apb(1, ERXCS_CTRL_OFS, 32'h0F);
    send(64, 0, ERXCS_CT_STD);
    chk(stat_out.status, 3'h1);
    send(64, 0, ERXCS_CT_PFC);
    chk(stat_out.status, 3'h2);
    apb(1, ERXCS_CTRL_OFS, 32'h0);
    send(64, 1, ERXCS_CT_NONE);
    chk(stat_out.fcs_valid, 1'b0);
    @(posedge pclk);
    #1 chk({stat_out.fcs_valid, stat_out.fcs_error}, 2'b11);
    send(64, 0, ERXCS_CT_NONE);
    chk(stat_out.fcs_valid, 1'b0);
    @(posedge pclk);
    #1 chk({stat_out.fcs_valid, stat_out.fcs_error}, 2'b10);
    $display("modes done");
    // masked event must not interrupt; unmasked must, until cleared
    apb(1, ERXCS_CTRL_OFS, 32'h11);
    apb(1, ERXCS_MASK_OFS, 32'h0);
    apb(1, ERXCS_IRQ_OFS, 32'hF);
    send(64, 1, ERXCS_CT_NONE);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    apb(1, ERXCS_MASK_OFS, 32'hF);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1, ERXCS_IRQ_OFS, 32'hF);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    apb(0, ERXCS_CNT_OFS, 0);
    chk(rd, 32'h4);
    apb(1, ERXCS_CNT_OFS, 0);
    apb(0, ERXCS_CNT_OFS, 0);
    chk(rd, 32'h0);
    apb(0, 32'hFF0, 0);
    chk({rerr, rd}, {1'b1, 32'h0});
    put(1, 1, 0, 8'h55);
    put(1, 0, 1, 8'hD5);
    chk(byte_out.ctl, 1'b1);
    put(1, 0, 0, 8'hA7);
    chk(byte_out, {1'b0, 8'hD5});
    put(0, 0, 0, 8'h00);
    chk(byte_out, {1'b0, 8'hA7});
    apb(1, ERXCS_CTRL_OFS, 32'h21);
    @(posedge pclk);
    #1 chk({ext, txc}, {1'b1, txin});
    chk(seen, 4);
    @(posedge cdr);
    #0.5 rxv = rxc;
    @(posedge cdr);
    #0.5 chk(rxc, !rxv);
    $display("hand tests done");
    finish_test;
  end
endmodule
